//--- rtl/imr_decode_exec.sv
// decode and execute of store, idle, config-load and return-with-literal
// Function
// - store_accumulator_op writes acc to file reg 0..31 in one cycle.
// - the config-load opcode copies acc into timer config in one cycle.
// - return_with_literal_op loads its 8-bit literal into acc.
// - return_with_literal_op reloads pc from stack_top_entry and pops it unless call_push is high that cycle (push wins).
// - return_with_literal_op takes two cycles; the prefetch is dropped.
`timescale 1ns/1ps
module imr_decode_exec #(
  parameter int PC_W = imr_pkg::PC_W
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic [imr_pkg::INSTR_W-1:0] fetch_word,
  input  wire logic                        call_push,
  input  wire logic [PC_W-1:0]             call_addr,
  output logic      [PC_W-1:0]             prog_addr,
  output logic      [imr_pkg::DATA_W-1:0]  acc,
  output logic      [imr_pkg::DATA_W-1:0]  timer_cfg,
  output logic                             file_we,
  output logic      [imr_pkg::FADDR_W-1:0] file_addr,
  output logic      [imr_pkg::DATA_W-1:0]  file_wdata,
  output logic                             flush
);
  // ----------------------------------------
  // checks and types
  // ----------------------------------------
  if (PC_W < 1 || PC_W > 16) begin : g_bad_pc
    $error("PC_W out of range");
  end

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } imr_state_t;

  // ----------------------------------------
  // state
  // ----------------------------------------
  imr_state_t                        state_q, state_d;
  logic [imr_pkg::INSTR_W-1:0]       ir_q, ir_d;
  logic [PC_W-1:0]                   pc_q, pc_d;
  logic [imr_pkg::DATA_W-1:0]        acc_q, acc_d;
  logic [imr_pkg::DATA_W-1:0]        cfg_q, cfg_d;
  logic                              we_q, we_d;
  logic [imr_pkg::FADDR_W-1:0]       fa_q, fa_d;
  logic [imr_pkg::DATA_W-1:0]        fd_q, fd_d;
  logic                              flush_q, flush_d;
  logic                              pop;
  logic [PC_W-1:0]                   stack_top_entry;
  logic                              is_store, is_cfg, is_ret, is_idle;

  imr_ret_stack #(.PC_W(PC_W)) u_stack (
    .clock           (clock),
    .rst_n           (rst_n),
    .push            (call_push),
    .push_addr       (call_addr),
    .pop             (pop),
    .stack_top_entry (stack_top_entry)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  always_comb begin
    is_store = (ir_q & imr_pkg::OPC_STORE_MASK) == imr_pkg::OPC_STORE;
    is_cfg   = ir_q == imr_pkg::OPC_CFG_LOAD;
    is_idle  = ir_q == imr_pkg::OPC_IDLE;
    is_ret   = (ir_q & imr_pkg::OPC_RETLIT_MSK) == imr_pkg::OPC_RETLIT;
  end

  // ----------------------------------------
  // execute
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    ir_d    = fetch_word;
    pc_d    = pc_q + PC_W'(1);
    acc_d   = acc_q;
    cfg_d   = cfg_q;
    we_d    = 1'b0;
    fa_d    = fa_q;
    fd_d    = fd_q;
    flush_d = 1'b0;
    pop     = 1'b0;
    case (state_q)
      ST_EXEC: begin
        if (is_store) begin
          we_d = 1'b1;
          fa_d = ir_q[imr_pkg::FADDR_W-1:0];
          fd_d = acc_q;
        end else if (is_cfg) begin
          cfg_d = acc_q;
        end else if (is_ret) begin
          acc_d   = ir_q[imr_pkg::DATA_W-1:0];
          pc_d    = stack_top_entry;
          pop     = 1'b1;
          // prefetched word is stale; replace with idle
          ir_d    = imr_pkg::OPC_IDLE;
          flush_d = 1'b1;
          state_d = ST_FLUSH;
        end else if (is_idle) begin
          pc_d = pc_q + PC_W'(1);
        end
        // other opcodes belong to other decoders
      end
      ST_FLUSH: begin
        state_d = ST_EXEC;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_EXEC;
      ir_q    <= imr_pkg::INSTR_RST;
      pc_q    <= PC_W'(imr_pkg::PC_RST);
      acc_q   <= imr_pkg::ACC_RST;
      cfg_q   <= imr_pkg::CFG_RST;
      we_q    <= 1'b0;
      fa_q    <= '0;
      fd_q    <= '0;
      flush_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_q    <= ir_d;
      pc_q    <= pc_d;
      acc_q   <= acc_d;
      cfg_q   <= cfg_d;
      we_q    <= we_d;
      fa_q    <= fa_d;
      fd_q    <= fd_d;
      flush_q <= flush_d;
    end
  end

  assign prog_addr  = pc_q;
  assign acc        = acc_q;
  assign timer_cfg  = cfg_q;
  assign file_we    = we_q;
  assign file_addr  = fa_q;
  assign file_wdata = fd_q;
  assign flush      = flush_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_STORE_WRITE: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_EXEC && is_store |=> file_we &&
      file_addr == $past(ir_q[imr_pkg::FADDR_W-1:0]) &&
      file_wdata == $past(acc_q) && acc == $past(acc_q))
    else $error("store did not write accumulator");
  AST_WE_ONLY_STORE: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(state_q == ST_EXEC && is_store) |=> !file_we)
    else $error("write without store");

  AST_IDLE_QUIET: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_EXEC && is_idle |=> !file_we && !flush &&
      $stable(acc_q) && $stable(cfg_q) &&
      pc_q == $past(pc_q) + PC_W'(1))
    else $error("idle changed state");
  // idle with no outside push must leave the return stack alone
  AST_IDLE_STACK: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_EXEC && is_idle && !call_push |=> $stable(stack_top_entry))
    else $error("idle touched the stack");
  AST_PC_STEP: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(state_q == ST_EXEC && is_ret) |=>
      prog_addr == $past(pc_q) + PC_W'(1))
    else $error("pc did not step by one");

  AST_CFG_LOAD: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_EXEC && is_cfg |=> timer_cfg == $past(acc_q) && !file_we)
    else $error("config not loaded");
  AST_CFG_HOLD: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(state_q == ST_EXEC && is_cfg) |=> timer_cfg == $past(cfg_q))
    else $error("config changed without load");

  AST_RET_ACC: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_EXEC && is_ret |=>
      acc == $past(ir_q[imr_pkg::DATA_W-1:0]))
    else $error("literal not in accumulator");
  // only a return may touch the accumulator in this block
  AST_ACC_HOLD: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(state_q == ST_EXEC && is_ret) |=> acc == $past(acc_q))
    else $error("accumulator changed without return");

  AST_RET_PC: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_EXEC && is_ret |=> prog_addr == $past(stack_top_entry))
    else $error("pc not from stack top");
  AST_POP_ONLY_RET: assert property (
    @(posedge clock) disable iff (!rst_n)
    pop |-> state_q == ST_EXEC && is_ret)
    else $error("stack popped without return");

  // the slot after a return holds the idle word, never the prefetch
  AST_RET_TWO: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_EXEC && is_ret |=> flush && state_q == ST_FLUSH &&
      is_idle ##1 state_q == ST_EXEC && !flush)
    else $error("return not two cycles");
  AST_FLUSH_SRC: assert property (
    @(posedge clock) disable iff (!rst_n)
    flush |-> $past(state_q) == ST_EXEC && $past(is_ret))
    else $error("flush without return");
  AST_NO_WE_FLUSH: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_FLUSH |=> !file_we)
    else $error("write during flushed cycle");
  AST_STATE_ONEHOT: assert property (
    @(posedge clock) disable iff (!rst_n)
    $onehot(state_q))
    else $error("state not one-hot");
endmodule

//--- common/imr_pkg.sv
// package: opcodes, widths and reset values for the decode/execute block
package imr_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int INSTR_W   = 12;
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 5;
  localparam int PC_W      = 11;
  localparam int STACK_D   = 2;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [11:0] OPC_IDLE       = 12'h000;
  localparam logic [11:0] OPC_CFG_LOAD   = 12'h002;
  localparam logic [11:0] OPC_STORE_MASK = 12'hfe0;
  localparam logic [11:0] OPC_STORE      = 12'h020;
  localparam logic [11:0] OPC_RETLIT_MSK = 12'hf00;
  localparam logic [11:0] OPC_RETLIT     = 12'h800;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  ACC_RST        = 8'h00;
  localparam logic [7:0]  CFG_RST        = 8'hff;
  localparam logic [10:0] PC_RST         = 11'h7ff;
  localparam logic [11:0] INSTR_RST      = 12'h000;
endpackage

//--- rtl/imr_ret_stack.sv
// two-entry hardware return stack with push and pop
`timescale 1ns/1ps
module imr_ret_stack #(
  parameter int PC_W = 11
) (
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            push,
  input  wire logic [PC_W-1:0] push_addr,
  input  wire logic            pop,
  output logic      [PC_W-1:0] stack_top_entry
);
  logic [PC_W-1:0] top_q, top_d;
  logic [PC_W-1:0] low_q, low_d;

  always_comb begin
    top_d = top_q;
    low_d = low_q;
    if (push) begin
      low_d = top_q;
      top_d = push_addr;
    end else if (pop) begin
      // pop copies the lower entry up; lower keeps its value
      top_d = low_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      top_q <= '0;
      low_q <= '0;
    end else begin
      top_q <= top_d;
      low_q <= low_d;
    end
  end

  assign stack_top_entry = top_q;
endmodule

//--- bench/test_instr_decode_move_return.sv
// self-checking bench for the decode/execute block
`timescale 1ns/1ps
module test_instr_decode_move_return;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clock;
  logic        rst_n;
  logic [11:0] fetch_word;
  logic        call_push;
  logic [10:0] call_addr;
  logic [10:0] prog_addr;
  logic [7:0]  acc;
  logic [7:0]  timer_cfg;
  logic        file_we;
  logic [4:0]  file_addr;
  logic [7:0]  file_wdata;
  logic        flush;
  logic [10:0] pc_seen;
  int          err_total;
  int          total_checks;

  imr_decode_exec i_dut (
    .clock      (clock),
    .rst_n      (rst_n),
    .fetch_word (fetch_word),
    .call_push  (call_push),
    .call_addr  (call_addr),
    .prog_addr  (prog_addr),
    .acc        (acc),
    .timer_cfg  (timer_cfg),
    .file_we    (file_we),
    .file_addr  (file_addr),
    .file_wdata (file_wdata),
    .flush      (flush)
  );

  always #2 clock = ~clock;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // inputs always move 1 ns after the edge, so no race with the flops
  task cyc;
    @(posedge clock);
    #1;
  endtask

  task chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task issue(input logic [11:0] w);
    fetch_word = w;
    cyc();
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task test_return;
    call_addr = 11'h155;
    call_push = 1'b1;
    cyc();
    call_addr = 11'h2aa;
    cyc();
    call_push = 1'b0;
    issue(12'h8aa);
    issue(12'h025); // fetched under the return, must be dropped
    chk(acc, 12'h0aa);
    chk(prog_addr, 12'h2aa);
    chk(flush, 12'h001);
    fetch_word = 12'h000;
    cyc();
    chk(flush, 12'h000);
    chk(file_we, 12'h000);
    issue(12'h8c3);
    issue(12'h000);
    chk(acc, 12'h0c3);
    chk(prog_addr, 12'h155);
    cyc();
    $display("test_return done");
  endtask

  task test_store;
    issue(12'h025);
    issue(12'h03f); // top file register, back to back
    chk(file_we, 12'h001);
    chk(file_addr, 12'h005);
    chk(file_wdata, 12'h0c3);
    fetch_word = 12'h000;
    cyc();
    chk(file_addr, 12'h01f);
    chk(file_we, 12'h001);
    cyc();
    chk(file_we, 12'h000);
    $display("test_store done");
  endtask

  task test_cfg;
    chk(timer_cfg, imr_pkg::CFG_RST);
    issue(12'h002);
    issue(12'h000);
    chk(timer_cfg, 12'h0c3);
    chk(acc, 12'h0c3);
    $display("test_cfg done");
  endtask

  task test_idle;
    cyc();
    pc_seen = prog_addr;
    cyc();
    chk(prog_addr, 11'(pc_seen + 11'h001));
    chk(acc, 12'h0c3);
    chk(timer_cfg, 12'h0c3);
    chk(file_we, 12'h000);
    chk(flush, 12'h000);
    $display("test_idle done");
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    fetch_word = 12'h000;
    call_push = 1'b0;
    call_addr = 11'h000;
    err_total = 0;
    total_checks = 0;
    repeat (8) cyc();
    chk(prog_addr, imr_pkg::PC_RST);
    chk(acc, imr_pkg::ACC_RST);
    chk(flush, 12'h000);
    rst_n = 1'b1;
    cyc();
    test_return();
    test_store();
    test_cfg();
    test_idle();
    complete_run();
  end
endmodule
